/* File: hw/usart_sync.sv */
// synchronous half-duplex serial transceiver, master and slave
//
// What this block does
// - load the shift register only after the last bit has gone out
// - a load takes one cycle, then buffer is empty and its flag sets
// - empty flag sets regardless of enable; only a buffer write clears it
// - shift-empty status is read-only and reads 1 while shifter is empty
// - the transmit shift register has no address; software cannot reach it
// - reception starts when continuous receive enable is set, or single receive enable in master mode
// - the data line is sampled on each falling shift clock edge
// - single receive takes exactly one word and then stops
// - continuous receive goes on until software clears its enable or an overrun error halts it
// - with both receive enables set, continuous reception applies
// - a full word sets the receive flag; interrupt only when enabled
// - clearing the continuous enable clears the error state
// - in slave mode the peer clocks the link; clock pin is not driven
// - clock source bit clear selects slave mode
// - sync bit plus port enable turn the pins into clock and data
// - half duplex: transmit blocks receive and receive blocks transmit
// - clock source bit set: the block drives the shift clock
`timescale 1ns/1ps
`default_nettype none
`include "usart_sync_consts.svh"

module usart_sync (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [7:0] rdData,
    input wire logic ckIn,
    output logic ckOut,
    output logic ckOe,
    input wire logic dtIn,
    output logic dtOut,
    output logic dtOe,
    output logic txIrq,
    output logic rxIrq
);

    usart_sync_pkg::port_state_t s_q;
    usart_sync_pkg::port_state_t s_d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic portOn;
        logic master;
        logic rxEnabled;
        logic rxRun;
        logic linkBusy;
        logic tick;
        logic riseEv;
        logic fallEv;
        logic txWrite;
        logic rxRead;
        logic lastTxFall;
        logic loadNow;
        logic [3:0] txBits;
        logic [3:0] rxBits;
        logic [8:0] rxNext;
        logic [7:0] rv;
        logic rxDone;
        portOn = 1'b0;
        master = 1'b0;
        rxEnabled = 1'b0;
        rxRun = 1'b0;
        linkBusy = 1'b0;
        tick = 1'b0;
        riseEv = 1'b0;
        fallEv = 1'b0;
        txWrite = 1'b0;
        rxRead = 1'b0;
        lastTxFall = 1'b0;
        loadNow = 1'b0;
        txBits = `BITS_EIGHT;
        rxBits = `BITS_EIGHT;
        rxNext = 9'h000;
        rv = `RESET_BYTE;
        rxDone = 1'b0;
        s_d = s_q;

        // pin synchronisers
        s_d.ckSync1 = ckIn;
        s_d.ckSync2 = s_q.ckSync1;
        s_d.ckPrev = s_q.ckSync2;
        s_d.dtSync1 = dtIn;
        s_d.dtSync2 = s_q.dtSync1;

        portOn = s_q.serialPortEnable & s_q.syncMode;
        master = s_q.clockSourceSelect;
        rxEnabled = portOn & (s_q.contRxEnable
            | (s_q.singleRxEnable & master));
        rxRun = rxEnabled & s_q.shiftEmpty & ~s_q.overrunError;
        linkBusy = ~s_q.shiftEmpty | rxRun;
        txBits = s_q.txNineBitEnable ? `BITS_NINE : `BITS_EIGHT;
        rxBits = s_q.rxNineBitEnable ? `BITS_NINE : `BITS_EIGHT;
        txWrite = wrStrobe & (addr == `ADDR_TX_HOLD);
        rxRead = rdStrobe & (addr == `ADDR_RX_BUF);

        // --------------------------------------------------------
        // shift clock
        // --------------------------------------------------------
        tick = (s_q.baudCnt == s_q.baudDivisor);
        if (portOn & master)
        begin
            if (linkBusy | s_q.ckOut)
            begin
                if (tick)
                begin
                    s_d.baudCnt = 8'h00;
                    s_d.ckOut = ~s_q.ckOut;
                    riseEv = ~s_q.ckOut;
                    fallEv = s_q.ckOut;
                end
                else
                begin
                    s_d.baudCnt = s_q.baudCnt + 8'h01;
                end
            end
            else
            begin
                s_d.baudCnt = 8'h00;
            end
        end
        else
        begin
            s_d.baudCnt = 8'h00;
            s_d.ckOut = 1'b0;
            if (portOn)
            begin
                riseEv = s_q.ckSync2 & ~s_q.ckPrev;
                fallEv = ~s_q.ckSync2 & s_q.ckPrev;
            end
        end
        s_d.ckOe = portOn & master;

        // --------------------------------------------------------
        // transmit shifter
        // --------------------------------------------------------
        if (~portOn | ~s_q.txEnable)
        begin
            s_d.shiftEmpty = 1'b1;
            s_d.txCnt = 4'h0;
            s_d.dtOe = 1'b0;
        end
        else if (~s_q.shiftEmpty)
        begin
            if (fallEv)
            begin
                s_d.txShift = {1'b0, s_q.txShift[8:1]};
                s_d.txCnt = s_q.txCnt + 4'h1;
                if (s_q.txCnt == txBits - 4'h1)
                begin
                    lastTxFall = 1'b1;
                    s_d.shiftEmpty = 1'b1;
                    s_d.txCnt = 4'h0;
                    s_d.dtOe = 1'b0;
                end
            end
            else if (riseEv)
            begin
                s_d.dtOut = s_q.txShift[0];
            end
        end

        loadNow = portOn & s_q.txEnable & s_q.txFull & ~rxEnabled
            & ~txWrite & (s_q.shiftEmpty | lastTxFall);
        if (loadNow)
        begin
            s_d.txShift = {s_q.txNinthBit, s_q.txHold};
            s_d.txFull = 1'b0;
            s_d.txBufEmptyFlag = 1'b1;
            s_d.shiftEmpty = 1'b0;
            s_d.txCnt = 4'h0;
            s_d.dtOut = s_q.txHold[0];
            s_d.dtOe = 1'b1;
        end

        // --------------------------------------------------------
        // receive shifter
        // --------------------------------------------------------
        if (~rxRun)
        begin
            s_d.rxCnt = 4'h0;
        end
        else if (fallEv)
        begin
            rxNext = {s_q.dtSync2, s_q.rxShift[8:1]};
            s_d.rxShift = rxNext;
            s_d.rxCnt = s_q.rxCnt + 4'h1;
            if (s_q.rxCnt == rxBits - 4'h1)
            begin
                s_d.rxCnt = 4'h0;
                rxDone = 1'b1;
                if (s_q.rxCompleteFlag & ~rxRead)
                begin
                    s_d.overrunError = 1'b1;
                end
                else
                begin
                    s_d.rxBuffer = s_q.rxNineBitEnable
                        ? rxNext[7:0] : rxNext[8:1];
                    s_d.rxNinthBit = s_q.rxNineBitEnable & rxNext[8];
                end
                s_d.rxCompleteFlag = ~s_q.overrunError
                    | s_q.rxCompleteFlag;
                if (~s_q.contRxEnable)
                begin
                    s_d.singleRxEnable = 1'b0;
                end
            end
        end

        // --------------------------------------------------------
        // register writes
        // --------------------------------------------------------
        if (wrStrobe)
        begin
            unique case (addr)
                `ADDR_FLAGS:
                begin
                    s_d.txBufEmptyFlag = s_d.txBufEmptyFlag;
                end
                `ADDR_ENABLES:
                begin
                    s_d.enables = wrData;
                end
                `ADDR_PRIORITIES:
                begin
                    s_d.priorities = wrData;
                end
                `ADDR_RX_STATUS:
                begin
                    s_d.serialPortEnable = wrData[`RXS_PORT_EN_BIT];
                    s_d.rxNineBitEnable = wrData[`RXS_NINE_BIT];
                    s_d.singleRxEnable = wrData[`RXS_SINGLE_BIT];
                    s_d.contRxEnable = wrData[`RXS_CONT_BIT];
                    s_d.addressDetectEnable = wrData[`RXS_ADDR_DET_BIT];
                    if (~wrData[`RXS_CONT_BIT])
                    begin
                        s_d.overrunError = 1'b0;
                    end
                end
                `ADDR_TX_HOLD:
                begin
                    s_d.txHold = wrData;
                    s_d.txFull = 1'b1;
                    s_d.txBufEmptyFlag = 1'b0;
                end
                `ADDR_TX_STATUS:
                begin
                    s_d.clockSourceSelect = wrData[`TXS_CLK_SRC_BIT];
                    s_d.txNineBitEnable = wrData[`TXS_NINE_BIT];
                    s_d.txEnable = wrData[`TXS_ENABLE_BIT];
                    s_d.syncMode = wrData[`TXS_SYNC_BIT];
                    s_d.highBaudSelect = wrData[`TXS_HIGH_BAUD_BIT];
                    s_d.txNinthBit = wrData[`TXS_NINTH_BIT];
                    if (wrData[`TXS_ENABLE_BIT] & ~s_q.txEnable
                        & ~s_q.txFull)
                    begin
                        s_d.txBufEmptyFlag = 1'b1;
                    end
                end
                `ADDR_BAUD:
                begin
                    s_d.baudDivisor = wrData;
                end
                `ADDR_RX_BUF:
                begin
                    s_d.rxBuffer = s_q.rxBuffer;
                end
            endcase
        end

        // --------------------------------------------------------
        // register reads
        // --------------------------------------------------------
        unique case (addr)
            `ADDR_FLAGS:
            begin
                rv[`FLAG_RX_BIT] = s_q.rxCompleteFlag;
                rv[`FLAG_TX_BIT] = s_q.txBufEmptyFlag;
            end
            `ADDR_ENABLES:
            begin
                rv = s_q.enables;
            end
            `ADDR_PRIORITIES:
            begin
                rv = s_q.priorities;
            end
            `ADDR_RX_STATUS:
            begin
                rv[`RXS_PORT_EN_BIT] = s_q.serialPortEnable;
                rv[`RXS_NINE_BIT] = s_q.rxNineBitEnable;
                rv[`RXS_SINGLE_BIT] = s_q.singleRxEnable;
                rv[`RXS_CONT_BIT] = s_q.contRxEnable;
                rv[`RXS_ADDR_DET_BIT] = s_q.addressDetectEnable;
                rv[`RXS_FRAMING_BIT] = 1'b0;
                rv[`RXS_OVERRUN_BIT] = s_q.overrunError;
                rv[`RXS_NINTH_BIT] = s_q.rxNinthBit;
            end
            `ADDR_TX_HOLD:
            begin
                rv = s_q.txHold;
            end
            `ADDR_TX_STATUS:
            begin
                rv[`TXS_CLK_SRC_BIT] = s_q.clockSourceSelect;
                rv[`TXS_NINE_BIT] = s_q.txNineBitEnable;
                rv[`TXS_ENABLE_BIT] = s_q.txEnable;
                rv[`TXS_SYNC_BIT] = s_q.syncMode;
                rv[`TXS_HIGH_BAUD_BIT] = s_q.highBaudSelect;
                rv[`TXS_SHIFT_EMPTY_BIT] = s_q.shiftEmpty;
                rv[`TXS_NINTH_BIT] = s_q.txNinthBit;
            end
            `ADDR_BAUD:
            begin
                rv = s_q.baudDivisor;
            end
            `ADDR_RX_BUF:
            begin
                rv = s_q.rxBuffer;
            end
        endcase
        s_d.rdData = rdStrobe ? rv : `RESET_BYTE;
        // reading the buffer frees it unless a word lands now
        if (rxRead & ~rxDone)
        begin
            s_d.rxCompleteFlag = 1'b0;
        end

        s_d.txIrq = s_d.txBufEmptyFlag & s_d.enables[`FLAG_TX_BIT];
        s_d.rxIrq = s_d.rxCompleteFlag & s_d.enables[`FLAG_RX_BIT];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.shiftEmpty <= 1'b1;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign rdData = s_q.rdData;
    assign ckOut = s_q.ckOut;
    assign ckOe = s_q.ckOe;
    assign dtOut = s_q.dtOut;
    assign dtOe = s_q.dtOe;
    assign txIrq = s_q.txIrq;
    assign rxIrq = s_q.rxIrq;

endmodule // usart_sync

`default_nettype wire

/* File: hw/usart_sync_consts.svh */
// register offsets, field positions and reset values of the serial port
`ifndef USART_SYNC_CONSTS_SVH
`define USART_SYNC_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_FLAGS 3'h0
`define ADDR_ENABLES 3'h1
`define ADDR_PRIORITIES 3'h2
`define ADDR_RX_STATUS 3'h3
`define ADDR_TX_HOLD 3'h4
`define ADDR_TX_STATUS 3'h5
`define ADDR_BAUD 3'h6
`define ADDR_RX_BUF 3'h7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FLAG_RX_BIT 5
`define FLAG_TX_BIT 4
`define RXS_PORT_EN_BIT 7
`define RXS_NINE_BIT 6
`define RXS_SINGLE_BIT 5
`define RXS_CONT_BIT 4
`define RXS_ADDR_DET_BIT 3
`define RXS_FRAMING_BIT 2
`define RXS_OVERRUN_BIT 1
`define RXS_NINTH_BIT 0
`define TXS_CLK_SRC_BIT 7
`define TXS_NINE_BIT 6
`define TXS_ENABLE_BIT 5
`define TXS_SYNC_BIT 4
`define TXS_HIGH_BAUD_BIT 2
`define TXS_SHIFT_EMPTY_BIT 1
`define TXS_NINTH_BIT 0

// ----------------------------------------------------------------
// word lengths and reset values
// ----------------------------------------------------------------
`define BITS_EIGHT 4'h8
`define BITS_NINE 4'h9
`define RESET_BYTE 8'h00
`define RESET_TX_STATUS 8'h02

`endif

/* File: hw/usart_sync_pkg.sv */
// types of the synchronous serial port
package usart_sync_pkg;

    // ------------------------------------------------------------
    // complete state of the port
    // ------------------------------------------------------------
    typedef struct packed {
        logic ckSync1;
        logic ckSync2;
        logic ckPrev;
        logic dtSync1;
        logic dtSync2;
        logic txBufEmptyFlag;
        logic rxCompleteFlag;
        logic [7:0] enables;
        logic [7:0] priorities;
        logic serialPortEnable;
        logic rxNineBitEnable;
        logic singleRxEnable;
        logic contRxEnable;
        logic addressDetectEnable;
        logic overrunError;
        logic rxNinthBit;
        logic clockSourceSelect;
        logic txNineBitEnable;
        logic txEnable;
        logic syncMode;
        logic highBaudSelect;
        logic shiftEmpty;
        logic txNinthBit;
        logic [7:0] txHold;
        logic txFull;
        logic [7:0] baudDivisor;
        logic [7:0] rxBuffer;
        logic [8:0] txShift;
        logic [3:0] txCnt;
        logic [8:0] rxShift;
        logic [3:0] rxCnt;
        logic [7:0] baudCnt;
        logic ckOut;
        logic ckOe;
        logic dtOut;
        logic dtOe;
        logic [7:0] rdData;
        logic txIrq;
        logic rxIrq;
    } port_state_t;

endpackage

/* File: test/sync_peer.sv */
// far side of the serial link: clock source, data source and listener
`timescale 1ns/1ps
`default_nettype none

module sync_peer (
    input wire logic ckOut,
    input wire logic ckOe,
    input wire logic dtOut,
    input wire logic dtOe,
    output wire logic ckLine,
    output wire logic dtLine
);
    // ----------------------------------------------------------------
    // line levels and peer state
    // ----------------------------------------------------------------
    logic peerCk = 1'b0;
    logic peerDt = 1'b0;
    logic floatDt = 1'b0;
    logic drive = 1'b0;
    logic listen = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [31:0] got = 32'h00000000;
    int idx = 0;
    int nGot = 0;
    wire dtLate;

    // peer clock unless the block drives it
    assign ckLine = ckOe ? ckOut : peerCk;
    assign dtLine = dtOe ? dtOut : (drive ? peerDt : floatDt);
    assign #1 dtLate = dtLine;

    always @(negedge dtOe)
        floatDt = ~dtOut;

    // take each bit at the falling edge
    always @(negedge ckLine)
    begin
        if (listen)
        begin
            got = {dtLate, got[31:1]};
            nGot++;
        end
        idx = (idx + 1) % 16;
    end

    // next bit goes out on the rising edge
    always @(posedge ckLine)
        if (drive)
            peerDt = word[idx];

    task automatic send(input logic [15:0] w);
        word = w;
        idx = 0;
        peerDt = w[0];
        drive = 1'b1;
    endtask

    task automatic letGo();
        floatDt = ~peerDt;
        drive = 1'b0;
    endtask

    task automatic hear();
        got = 32'h00000000;
        nGot = 0;
        listen = 1'b1;
    endtask

    // slave clock pulses, still between frames
    task automatic pulses(input int n);
        repeat (n)
        begin
            #100 peerCk = 1'b1;
            #100 peerCk = 1'b0;
        end
    endtask
endmodule // sync_peer

`default_nettype wire

/* File: test/usart_sync_asserts.sv */
// checker of the serial port's register and pin behaviour
`timescale 1ns/1ps
`default_nettype none
`include "usart_sync_consts.svh"

module usart_sync_asserts (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [7:0] rdData,
    input wire logic ckOut,
    input wire logic ckOe,
    input wire logic dtOe,
    input wire logic txIrq,
    input wire logic rxIrq
);
    // ----------------------------------------------------------------
    // copies of written registers, clock history and phase length
    // ----------------------------------------------------------------
    logic [7:0] enW_q;
    logic [7:0] rxsW_q;
    logic [7:0] txsW_q;
    logic [7:0] baudW_q;
    logic ckPrev_q;
    logic [7:0] run_q;

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            enW_q <= `RESET_BYTE;
            rxsW_q <= `RESET_BYTE;
            txsW_q <= `RESET_TX_STATUS;
            baudW_q <= `RESET_BYTE;
            ckPrev_q <= 1'b0;
            run_q <= 8'h00;
        end
        else
        begin
            enW_q <= (wrStrobe && addr == `ADDR_ENABLES) ? wrData : enW_q;
            rxsW_q <= (wrStrobe && addr == `ADDR_RX_STATUS) ? wrData : rxsW_q;
            txsW_q <= (wrStrobe && addr == `ADDR_TX_STATUS) ? wrData : txsW_q;
            baudW_q <= (wrStrobe && addr == `ADDR_BAUD) ? wrData : baudW_q;
            ckPrev_q <= ckOut;
            run_q <= (ckOut != ckPrev_q) ? 8'h01 : run_q + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence readOf(logic [2:0] a);
        rdStrobe && addr == a;
    endsequence
    sequence masterOn;
        txsW_q[7] && txsW_q[4] && rxsW_q[7];
    endsequence

    read_idle_zero_a:
        assert property (!$past(rdStrobe) |-> rdData == 8'h00)
        else $error("read data not zero outside a read");
    tx_status_read_a:
        assert property (readOf(`ADDR_TX_STATUS) |=>
            rdData[7:2] == {txsW_q[7:4], 1'b0, txsW_q[2]})
        else $error("tx status reads back wrong");
    baud_read_a:
        assert property (readOf(`ADDR_BAUD) |=> rdData == baudW_q)
        else $error("divisor reads back wrong");
    busy_not_empty_a:
        assert property (rdStrobe && addr == `ADDR_TX_STATUS && dtOe
            && $past(dtOe) |=> !rdData[1])
        else $error("shift empty set while shifting");
    load_sets_flag_a:
        assert property ($rose(dtOe) && enW_q[4] |-> ##[0:2] txIrq)
        else $error("buffer empty flag missing after load");
    rx_irq_gate_a:
        assert property (rxIrq |-> enW_q[5] || $past(enW_q[5]))
        else $error("receive interrupt while disabled");
    clock_half_a:
        assert property (!ckOut && ckPrev_q && txsW_q[7] |->
            run_q == baudW_q + 8'h01)
        else $error("shift clock high phase wrong length");
    master_clock_a:
        assert property (masterOn [*3] |-> ckOe)
        else $error("master does not drive the clock");
    slave_no_clock_a:
        assert property (!txsW_q[7] [*3] |-> !ckOe)
        else $error("slave drives the clock pin");
    rx_blocks_tx_a:
        assert property (rxsW_q[4] [*2] |-> !$rose(dtOe))
        else $error("word loaded while receiving");
    port_off_idle_a:
        assert property (!rxsW_q[7] [*3] |-> !dtOe && !ckOe)
        else $error("pins driven with port disabled");
endmodule // usart_sync_asserts

bind usart_sync usart_sync_asserts chk (.mclk, .reset_n, .addr, .wrData,
    .wrStrobe, .rdStrobe, .rdData, .ckOut, .ckOe, .dtOe, .txIrq, .rxIrq);

`default_nettype wire

/* File: test/usart_sync_tb.sv */
// testbench of the synchronous serial port
`timescale 1ns/1ps
`default_nettype none
`include "usart_sync_consts.svh"

module usart_sync_tb;
    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wrData = 8'h00;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic [7:0] rdData;
    logic ckOut;
    logic ckOe;
    logic dtOut;
    logic dtOe;
    logic txIrq;
    logic rxIrq;
    wire ckLine;
    wire dtLine;
    logic [7:0] d;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;

    usart_sync dut (.mclk, .reset_n, .ce, .addr, .wrData, .wrStrobe,
        .rdStrobe, .rdData, .ckIn(ckLine), .ckOut, .ckOe, .dtIn(dtLine),
        .dtOut, .dtOe, .txIrq, .rxIrq);
    sync_peer peer (.ckOut, .ckOe, .dtOut, .dtOe, .ckLine, .dtLine);

    initial
    begin
        forever
            #12.5 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wrData <= v;
        wrStrobe <= 1'b1;
        @(posedge mclk);
        wrStrobe <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge mclk);
        rdStrobe <= 1'b0;
        #1 v = rdData;
    endtask

    task automatic rdChk(input string what, input logic [2:0] a,
        input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        check(what, {24'h0, v}, {24'h0, e});
    endtask

    task automatic waitBit(input logic [2:0] a, input int b, input logic v);
        logic [7:0] x;
        int n;
        n = 0;
        rd(a, x);
        while (x[b] !== v && n < 600)
        begin
            rd(a, x);
            n++;
        end
        check("poll", {31'h0, x[b]}, {31'h0, v});
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rdChk("reset", 3'(i),
                (i == 5) ? `RESET_TX_STATUS : `RESET_BYTE);
        wr(`ADDR_FLAGS, 8'hFF);
        wr(`ADDR_RX_BUF, 8'hFF);
        rdChk("flags ro", `ADDR_FLAGS, 8'h00);
        rdChk("rx buffer ro", `ADDR_RX_BUF, 8'h00);
        peer.hear();
        wr(`ADDR_BAUD, 8'h07);
        wr(`ADDR_RX_STATUS, 8'h80);
        wr(`ADDR_TX_STATUS, 8'hB0);
        rdChk("baud", `ADDR_BAUD, 8'h07);
        rdChk("flag unmasked", `ADDR_FLAGS, 8'h10);
        wr(`ADDR_ENABLES, 8'h10);
        wr(`ADDR_TX_HOLD, 8'hA5);
        wr(`ADDR_TX_HOLD, 8'h3C);
        rdChk("tx busy", `ADDR_TX_STATUS, 8'hB0);
        rdChk("buffer full", `ADDR_FLAGS, 8'h00);
        check("tx irq off", {31'h0, txIrq}, 32'h0);
        waitBit(`ADDR_TX_STATUS, 1, 1'b1);
        check("bit count", peer.nGot, 32'd16);
        check("two words", {16'h0, peer.got[31:16]}, 32'h3CA5);
        rdChk("tx idle", `ADDR_TX_STATUS, 8'hB2);
        rdChk("flag back", `ADDR_FLAGS, 8'h10);
        check("tx irq on", {31'h0, txIrq}, 32'h1);
        peer.hear();
        wr(`ADDR_TX_STATUS, 8'hF1);
        wr(`ADDR_TX_HOLD, 8'h5A);
        waitBit(`ADDR_TX_STATUS, 1, 1'b1);
        check("nine bits", {23'h0, peer.got[31:23]}, 32'h15A);
        rdChk("hold kept", `ADDR_TX_HOLD, 8'h5A);
        wr(`ADDR_TX_STATUS, 8'h90);
        wr(`ADDR_ENABLES, 8'h20);
        peer.send(16'h00C3);
        wr(`ADDR_RX_STATUS, 8'hA0);
        waitBit(`ADDR_FLAGS, 5, 1'b1);
        repeat (2) @(posedge mclk);
        check("rx irq on", {31'h0, rxIrq}, 32'h1);
        repeat (300) @(posedge mclk);
        rd(`ADDR_RX_STATUS, d);
        check("single word", {31'h0, d[1]}, 32'h0);
        rdChk("rx word", `ADDR_RX_BUF, 8'hC3);
        rd(`ADDR_FLAGS, d);
        check("rx flag clear", {31'h0, d[5]}, 32'h0);
        wr(`ADDR_RX_STATUS, 8'h80);
        wr(`ADDR_ENABLES, 8'h00);
        peer.send(16'h3412);
        wr(`ADDR_RX_STATUS, 8'hB0);
        waitBit(`ADDR_RX_STATUS, 1, 1'b1);
        check("rx irq masked", {31'h0, rxIrq}, 32'h0);
        rdChk("kept word", `ADDR_RX_BUF, 8'h12);
        wr(`ADDR_RX_STATUS, 8'h80);
        rdChk("error gone", `ADDR_RX_STATUS, 8'h80);
        wr(`ADDR_TX_STATUS, 8'h10);
        repeat (4) @(posedge mclk);
        check("slave clock", {31'h0, ckOe}, 32'h0);
        peer.send(16'h0096);
        wr(`ADDR_RX_STATUS, 8'h90);
        peer.pulses(8);
        waitBit(`ADDR_FLAGS, 5, 1'b1);
        rdChk("slave word", `ADDR_RX_BUF, 8'h96);
        peer.letGo();
        wr(`ADDR_RX_STATUS, 8'h80);
        wr(`ADDR_TX_STATUS, 8'h30);
        peer.hear();
        wr(`ADDR_TX_HOLD, 8'h69);
        peer.pulses(8);
        waitBit(`ADDR_TX_STATUS, 1, 1'b1);
        check("slave tx", {24'h0, peer.got[31:24]}, 32'h69);
        final_report();
    end
endmodule // usart_sync_tb

`default_nettype wire
